// File: core/asram_host.sv
// Host controller that drives an asynchronous 8192 by 8 static memory through its pins.
// Summary of operation
// - Access needs low-active select low and high-active select high together.
// - Read holds write strobe high; output strobe low makes memory drive.
// - Storage happens only while write strobe and both selects are active.
// - Write ends at the first deasserting edge; recovery counts from there.
// - Host never drives data lines while the memory may still drive.
// - With output strobe low, write pulse covers turn-off plus overlap.
// - With output strobe high, write pulse may be minimum width.
`timescale 1ns/1ps
`include "asram_map.svh"
module asram_host
    import asram_pkg::*;
#(
    parameter int AW = `ASRAM_ADDR_W,
    parameter int DW = `ASRAM_DATA_W
)
(
    // Clock and reset.
    input  wire logic          CLOCK_IN,
    input  wire logic          RST_N_IN,
    // User request side.
    input  wire logic          REQ_VALID_IN,
    input  wire asram_req_t    REQ_IN,
    output logic               REQ_READY_OUT,
    output logic               RD_VALID_OUT,
    output logic [DW-1:0]      RD_DATA_OUT,
    // Memory pins.
    output logic [AW-1:0]      WORD_INDEX_OUT,
    output asram_ctl_t         CTL_OUT,
    output logic [DW-1:0]      DATA_LINES_OUT,
    output logic               DATA_LINES_OE_OUT,
    input  wire logic [DW-1:0] DATA_LINES_IN
);
    typedef enum logic [2:0] {ST_IDLE, ST_WSET, ST_WPULSE, ST_WREC, ST_RACC, ST_RCAP} asram_st_t;

    localparam int WPC = `ASRAM_WP_CYC;
    localparam int OVC = `ASRAM_WHZDW_CYC;
    localparam int WPULSE = (WPC > OVC) ? WPC : OVC;
    localparam int ACC = `ASRAM_ACC_CYC + 2;
    localparam int REC = `ASRAM_WR_CYC;

    asram_st_t   st_q;
    logic [3:0]  tload_cnt;
    logic        tload;
    logic        tdone;
    logic [DW-1:0] din_s1_q;
    logic [DW-1:0] din_s2_q;
    asram_ctl_t  ctl_q;

    ////////////////////////////////////////////////////////////////////////////////

    asram_timer #(.W(4)) u_timer
    (
        .clk_in   (CLOCK_IN),
        .rst_n_in (RST_N_IN),
        .load_in  (tload),
        .count_in (tload_cnt),
        .done_out (tdone)
    );

    always_comb
    begin
        tload = 1'b0;
        tload_cnt = 4'h0;
        case (st_q)
            ST_IDLE:
            begin
                tload = REQ_VALID_IN;
                tload_cnt = REQ_IN.write ? 4'h1 : 4'(ACC);
            end
            ST_WSET:
            begin
                tload = tdone;
                tload_cnt = 4'(WPULSE);
            end
            ST_WPULSE:
            begin
                tload = tdone;
                tload_cnt = 4'(REC);
            end
            default:
            begin
                tload = 1'b0;
                tload_cnt = 4'h0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
            st_q <= ST_IDLE;
        else
            case (st_q)
                ST_IDLE:   if (REQ_VALID_IN) st_q <= REQ_IN.write ? ST_WSET : ST_RACC;
                ST_WSET:   if (tdone) st_q <= ST_WPULSE;
                ST_WPULSE: if (tdone) st_q <= ST_WREC;
                ST_WREC:   if (tdone) st_q <= ST_IDLE;
                ST_RACC:   if (tdone) st_q <= ST_RCAP;
                ST_RCAP:   st_q <= ST_IDLE;
                default:   st_q <= ST_IDLE;
            endcase
    end

    // Selects assert only during an access; output strobe stays high on writes.
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
            ctl_q <= '{sel_low_n: 1'b1, sel_high: 1'b0, wstrobe_n: 1'b1, ostrobe_n: 1'b1};
        else
            case (st_q)
                ST_IDLE:
                    if (REQ_VALID_IN)
                        ctl_q <= '{sel_low_n: 1'b0, sel_high: 1'b1, wstrobe_n: 1'b1,
                                   ostrobe_n: REQ_IN.write};
                    else
                        ctl_q <= '{sel_low_n: 1'b1, sel_high: 1'b0, wstrobe_n: 1'b1,
                                   ostrobe_n: 1'b1};
                ST_WSET:   if (tdone) ctl_q.wstrobe_n <= 1'b0;
                ST_WPULSE: if (tdone) ctl_q.wstrobe_n <= 1'b1;
                ST_WREC:   if (tdone) ctl_q <= '{1'b1, 1'b0, 1'b1, 1'b1};
                ST_RCAP:   ctl_q <= '{1'b1, 1'b0, 1'b1, 1'b1};
                default:   ctl_q <= ctl_q;
            endcase
    end

    assign CTL_OUT = ctl_q;

    // Word index and write data are latched once and held through the access.
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            WORD_INDEX_OUT <= '0;
            DATA_LINES_OUT <= '0;
        end
        else if (st_q == ST_IDLE && REQ_VALID_IN)
        begin
            WORD_INDEX_OUT <= REQ_IN.index;
            DATA_LINES_OUT <= REQ_IN.wdata;
        end
    end

    // The host drives the bus only while output strobe is high during a write.
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
            DATA_LINES_OE_OUT <= 1'b0;
        else if (st_q == ST_IDLE)
            DATA_LINES_OE_OUT <= REQ_VALID_IN && REQ_IN.write;
        else if (st_q == ST_WREC && tdone)
            DATA_LINES_OE_OUT <= 1'b0;
    end

    // Data lines pass two flip-flops before capture; the memory needs no clock.
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            din_s1_q <= '0;
            din_s2_q <= '0;
        end
        else
        begin
            din_s1_q <= DATA_LINES_IN;
            din_s2_q <= din_s1_q;
        end
    end

    always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            RD_VALID_OUT <= 1'b0;
            RD_DATA_OUT  <= '0;
        end
        else
        begin
            RD_VALID_OUT <= (st_q == ST_RCAP);
            if (st_q == ST_RCAP)
                RD_DATA_OUT <= din_s2_q;
        end
    end

    always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
            REQ_READY_OUT <= 1'b0;
        else
            REQ_READY_OUT <= ((st_q == ST_IDLE) && !REQ_VALID_IN)
                             || ((st_q == ST_WREC) && tdone) || (st_q == ST_RCAP);
    end

    ////////////////////////////////////////////////////////////////////////////////

    chk_write_needs_sel : assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        !CTL_OUT.wstrobe_n |-> !CTL_OUT.sel_low_n && CTL_OUT.sel_high)
        else $error("Write strobe low while not selected.");
    chk_no_contention : assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        DATA_LINES_OE_OUT |-> CTL_OUT.ostrobe_n)
        else $error("Host drives bus while output strobe low.");
    chk_pulse_width : assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        $fell(CTL_OUT.wstrobe_n) |-> !CTL_OUT.wstrobe_n [*1] ##1 !CTL_OUT.wstrobe_n)
        else $error("Write pulse too short.");
    chk_sel_before_we : assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        $fell(CTL_OUT.wstrobe_n) |-> $past(!CTL_OUT.sel_low_n && CTL_OUT.sel_high))
        else $error("Select not set up before write strobe.");
    chk_index_stable : assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        !CTL_OUT.sel_low_n && $past(!CTL_OUT.sel_low_n) |-> $stable(WORD_INDEX_OUT))
        else $error("Word index changed during access.");
    chk_we_first_end : assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        $rose(CTL_OUT.wstrobe_n) |-> !CTL_OUT.sel_low_n && CTL_OUT.sel_high)
        else $error("Write not ended by write strobe first.");
    chk_read_we_high : assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        !CTL_OUT.ostrobe_n |-> CTL_OUT.wstrobe_n && !DATA_LINES_OE_OUT)
        else $error("Read with write strobe low or host driving.");
    chk_idle_standby : assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        $rose(REQ_READY_OUT) |-> CTL_OUT.sel_low_n && !CTL_OUT.sel_high)
        else $error("Memory left selected while idle.");
    chk_read_done : assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        $fell(CTL_OUT.ostrobe_n) |-> ##[1:12] RD_VALID_OUT)
        else $error("Read result missing.");
endmodule

// File: include/asram_map.svh
// Pin-level constants and timing counts for the static memory host controller.
`ifndef ASRAM_MAP_SVH
`define ASRAM_MAP_SVH
`define ASRAM_ADDR_W        13
`define ASRAM_DATA_W        8
`define ASRAM_WORDS         8192
`define ASRAM_CLK_NS        100
`define ASRAM_WP_NS         25
`define ASRAM_WHZ_NS        14
`define ASRAM_DW_NS         15
`define ASRAM_ACC_NS        40
`define ASRAM_WR_NS         5
`define ASRAM_WP_CYC        ((`ASRAM_WP_NS + `ASRAM_CLK_NS - 1) / `ASRAM_CLK_NS)
`define ASRAM_WHZDW_CYC     ((`ASRAM_WHZ_NS + `ASRAM_DW_NS + `ASRAM_CLK_NS - 1) / `ASRAM_CLK_NS)
`define ASRAM_ACC_CYC       ((`ASRAM_ACC_NS + `ASRAM_CLK_NS - 1) / `ASRAM_CLK_NS)
`define ASRAM_WR_CYC        ((`ASRAM_WR_NS + `ASRAM_CLK_NS - 1) / `ASRAM_CLK_NS)
`endif

// File: include/asram_pkg.sv
// Types shared by the static memory host controller.
package asram_pkg;
    typedef struct packed
    {
        logic        write;
        logic [12:0] index;
        logic [7:0]  wdata;
    } asram_req_t;
    typedef struct packed
    {
        logic        sel_low_n;
        logic        sel_high;
        logic        wstrobe_n;
        logic        ostrobe_n;
    } asram_ctl_t;
endpackage

// File: core/asram_timer.sv
// Down counter that flags the end of a programmed wait.
`timescale 1ns/1ps
module asram_timer
#(
    parameter int W = 4
)
(
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    input  wire logic         load_in,
    input  wire logic [W-1:0] count_in,
    output logic              done_out
);
    logic [W-1:0] cnt_q;

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            cnt_q <= '0;
        else if (load_in)
            cnt_q <= count_in;
        else if (cnt_q != '0)
            cnt_q <= cnt_q - 1'b1;
    end

    // Done depends on the count alone, so a load driven from done forms no loop.
    assign done_out = (cnt_q == '0);
endmodule

// File: verif/asram_mem_model.sv
// Behavioural model of the 8192 by 8 static memory on the host pins.
`timescale 1ns/1ps
module asram_mem_model
    import asram_pkg::*;
(
    // Host pins.
    input  wire logic [12:0] word_index_in,
    input  wire asram_ctl_t  ctl_in,
    input  wire logic [7:0]  bus_in,
    // Memory drive.
    output logic      [7:0]  data_out,
    output logic             oe_out
);
    logic [7:0] mem [0:8191];
    logic [7:0] last_q = 8'h00;
    logic       sel;
    assign sel = !ctl_in.sel_low_n && ctl_in.sel_high;
    assign oe_out = sel && ctl_in.wstrobe_n && !ctl_in.ostrobe_n;
    // A released bus shows the inverse of the last word driven.
    assign data_out = oe_out ? mem[word_index_in] : ~last_q;
    always @(word_index_in or ctl_in or bus_in or sel or oe_out)
    begin
        if (sel && !ctl_in.wstrobe_n)
        begin
            mem[word_index_in] = bus_in;
        end
        if (oe_out)
        begin
            last_q = mem[word_index_in];
        end
    end
endmodule

// File: verif/asram_host_tb.sv
// Self-checking testbench for the static memory host controller.
`timescale 1ns/1ps
module asram_host_tb
    import asram_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        req_valid = 1'b0;
    asram_req_t  req = '0;
    logic        ready, rd_valid, host_oe, mem_oe;
    logic [7:0]  rd_data, host_data, mem_data, bus;
    logic [12:0] index, wr_idx;
    asram_ctl_t  ctl;
    int          fail_count = 0;
    int          num_checks = 0;
    always #50 clk = ~clk;
    assign bus = host_oe ? host_data : mem_data;
    asram_host u_asram_host (.CLOCK_IN(clk), .RST_N_IN(rst_n), .REQ_VALID_IN(req_valid),
        .REQ_IN(req), .REQ_READY_OUT(ready), .RD_VALID_OUT(rd_valid), .RD_DATA_OUT(rd_data),
        .WORD_INDEX_OUT(index), .CTL_OUT(ctl), .DATA_LINES_OUT(host_data),
        .DATA_LINES_OE_OUT(host_oe), .DATA_LINES_IN(bus));
    asram_mem_model u_asram_mem_model (.word_index_in(index), .ctl_in(ctl), .bus_in(bus),
        .data_out(mem_data), .oe_out(mem_oe));
    task automatic check(input string what, input logic [12:0] exp, input logic [12:0] got);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Waits a bounded time for ready or, with rd set, for read data valid.
    task automatic await(input bit rd);
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while (((rd ? rd_valid : ready) !== 1'b1) && n < 40);
        check("handshake", 13'h1, {12'h0, n < 40});
        if (n >= 40)
            tally_and_finish();
    endtask
    task automatic access(input logic wr, input logic [12:0] idx, input logic [7:0] d);
        await(1'b0);
        req = '{write: wr, index: idx, wdata: d};
        req_valid = 1'b1;
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        if (!wr)
            await(1'b1);
    endtask
    task automatic rd_word(input logic [12:0] idx, input logic [7:0] exp);
        access(1'b0, idx, 8'h00);
        check("read data", {5'h0, exp}, {5'h0, rd_data});
    endtask
    // Pin checks that hold on every edge out of reset.
    always @(posedge clk)
    begin
        if (rst_n)
        begin
            check("bus contention", 13'h0, {12'h0, host_oe && mem_oe});
            if (ctl.wstrobe_n)
                wr_idx <= index;
            else
            begin
                check("index during write", wr_idx, index);
                check("write strobes", 13'h3,
                      {11'h0, ctl.ostrobe_n, !ctl.sel_low_n && ctl.sel_high});
            end
        end
    end
    task automatic t_reset();
        check("ctl in reset", 13'hB, {9'h0, ctl});
        check("oe in reset", 13'h0, {11'h0, host_oe, rd_valid});
        $display("test reset done");
    endtask
    task automatic t_boundary();
        access(1'b1, 13'h0000, 8'hA5);
        access(1'b1, 13'h1FFF, 8'h5A);
        rd_word(13'h0000, 8'hA5);
        rd_word(13'h1FFF, 8'h5A);
        $display("test boundary done");
    endtask
    task automatic t_walk();
        for (int i = 0; i < 13; i++)
            access(1'b1, 13'h1 << i, 8'h1 << (i % 8));
        for (int i = 0; i < 13; i++)
            rd_word(13'h1 << i, 8'h1 << (i % 8));
        $display("test walk done");
    endtask
    task automatic t_overwrite();
        access(1'b1, 13'h0123, 8'h11);
        access(1'b1, 13'h0123, 8'hEE);
        rd_word(13'h0123, 8'hEE);
        rd_word(13'h0000, 8'hA5);
        $display("test overwrite done");
    endtask
    task automatic t_idle();
        await(1'b0);
        repeat (3) @(posedge clk);
        #1;
        check("ctl when idle", 13'hB, {9'h0, ctl});
        check("oe when idle", 13'h0, {12'h0, host_oe});
        $display("test idle done");
    endtask
    task automatic t_mid_reset();
        access(1'b1, 13'h0042, 8'h3C);
        @(posedge clk);
        #1;
        rst_n = 1'b0;
        #1;
        check("ctl after abort", 13'hB, {9'h0, ctl});
        check("oe after abort", 13'h0, {12'h0, host_oe});
        repeat (8) @(posedge clk);
        #1;
        rst_n = 1'b1;
        access(1'b1, 13'h0042, 8'hC3);
        rd_word(13'h0042, 8'hC3);
        $display("test mid reset done");
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        t_reset();
        #1;
        rst_n = 1'b1;
        t_boundary();
        t_walk();
        t_overwrite();
        t_idle();
        t_mid_reset();
        tally_and_finish();
    end
endmodule
